// ==== hdl/dma_chan_pkg.sv ====
package dma_chan_pkg;
    // ----------------------------------------------------------------
    // Register map (word addresses on avs_address, one per register)
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_COUNT = 4'h1;
    localparam logic [3:0] OFS_PERIPH = 4'h2;
    localparam logic [3:0] OFS_MEM = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MASK = 4'h5;
    localparam logic [3:0] OFS_CUR_PA = 4'h6;
    localparam logic [3:0] OFS_CUR_MA = 4'h7;
    // ----------------------------------------------------------------
    // Channel configuration fields
    // ----------------------------------------------------------------
    localparam int CFG_EN = 0;
    localparam int CFG_FULL_IE = 1;
    localparam int CFG_HALF_IE = 2;
    localparam int CFG_DIR = 4;
    localparam int CFG_WRAP = 5;
    localparam int CFG_PERIPH_ADDR_STEP_EN = 6;
    localparam int CFG_MEM_ADDR_STEP_EN = 7;
    localparam int CFG_PERIPH_ITEM_WIDTH = 8;
    localparam int CFG_MEM_ITEM_WIDTH = 10;
    localparam int CFG_PL = 12;
    localparam int CFG_MCOPY = 14;
    localparam int CFG_BITS = 15;
    localparam int STAT_HALF = 0;
    localparam int STAT_FULL = 1;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam int COUNT_BITS = 16;
    // ----------------------------------------------------------------
    // Item widths and engine states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        W8 = 2'b00,
        W16 = 2'b01,
        W32 = 2'b10
    } width_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WRITE = 3'b010,
        ST_ACK = 3'b011,
        ST_DONE = 3'b100
    } state_t;

    function automatic logic [31:0] step_of(input logic [1:0] w);
        case (w)
            W8: step_of = 32'h0000_0001;
            W16: step_of = 32'h0000_0002;
            default: step_of = 32'h0000_0004;
        endcase
    endfunction : step_of

    function automatic logic [31:0] trim(input logic [31:0] d,
                                        input logic [1:0] w);
        case (w)
            W8: trim = {24'h00_0000, d[7:0]};
            W16: trim = {16'h0000, d[15:0]};
            default: trim = d;
        endcase
    endfunction : trim
endpackage : dma_chan_pkg

// ==== hdl/dma_sys_if.sv ====
`timescale 1ns/10ps
interface dma_sys_if;
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [1:0] size;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
    modport engine (output req, output wr, output addr, output size,
        output wdata, input rdata, input done);
    modport port (input req, input wr, input addr, input size,
        input wdata, output rdata, output done);
endinterface : dma_sys_if

// ==== hdl/dma_sys_port.sv ====
`timescale 1ns/10ps
module dma_sys_port
    import dma_chan_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    dma_sys_if.port sp,
    output logic m_read,
    output logic m_write,
    output logic [31:0] m_address,
    output logic [3:0] m_byteenable,
    output logic [31:0] m_writedata,
    input wire logic [31:0] m_readdata,
    input wire logic m_waitrequest
);
    // ----------------------------------------------------------------
    // Avalon master: one access per engine request
    // ----------------------------------------------------------------
    logic busy_r, busy_nxt;
    logic [3:0] be;
    always_comb begin
        case (sp.size)
            W8: be = 4'h1 << sp.addr[1:0];
            W16: be = sp.addr[1] ? 4'hC : 4'h3;
            default: be = 4'hF;
        endcase
        busy_nxt = busy_r;
        if (!busy_r && sp.req) begin
            busy_nxt = 1'b1;
        end else if (busy_r && !m_waitrequest) begin
            busy_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            m_read <= 1'b0;
            m_write <= 1'b0;
            m_address <= RESET_WORD;
            m_byteenable <= 4'h0;
            m_writedata <= RESET_WORD;
        end else begin
            busy_r <= busy_nxt;
            if (!busy_r && sp.req) begin
                m_read <= !sp.wr;
                m_write <= sp.wr;
                m_address <= {sp.addr[31:2], 2'b00};
                m_byteenable <= be;
                m_writedata <= sp.wdata << {sp.addr[1:0], 3'b000};
            end else if (busy_r && !m_waitrequest) begin
                m_read <= 1'b0;
                m_write <= 1'b0;
            end
        end
    end
    // Read lanes shifted down so the engine sees the item in low bits
    assign sp.done = busy_r && !m_waitrequest;
    assign sp.rdata = m_readdata >> {m_address[1:0] | sp.addr[1:0], 3'b000};
endmodule : dma_sys_port

// ==== hdl/dma_channel_transfer_engine.sv ====
`timescale 1ns/10ps
// Function
// R1: Program addresses, count, config, enable last
// R2: Enabled channel serves its peripheral requests
// R3: Each event moves one item per direction
// R4: Count decrements after each transfer
// R5: Half point sets half flag, interrupt
// R6: Last item sets full flag, interrupt
// R7: Wraparound reloads count and keeps serving
// R8: Memory copy starts on enable alone
// R9: Memory copy stops at zero count
// R10: Never memory copy with wraparound; code accepts CFG_MCOPY with CFG_WRAP and repeats the copy
// R11: Read at source width, write destination
// R12: Wider destination zero fills upper bits
// R13: Narrower destination keeps low bits
// R14: Each side steps by its own size
// R15: Request held until ack, ack follows
// R16: No wraparound: stop at zero; count while disabled
// R17: Wraparound reloads current addresses
// R18: Step 1, 2 or 4 by item size
// R19: Disable blocks starting further items
module dma_channel_transfer_engine
    import dma_chan_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic periph_req,
    output logic periph_ack,
    output logic m_read,
    output logic m_write,
    output logic [31:0] m_address,
    output logic [3:0] m_byteenable,
    output logic [31:0] m_writedata,
    input wire logic [31:0] m_readdata,
    input wire logic m_waitrequest
);
    // ----------------------------------------------------------------
    // Registers and synchroniser
    // ----------------------------------------------------------------
    dma_sys_if sys ();
    logic [CFG_BITS-1:0] cfg_r, cfg_nxt;
    logic [COUNT_BITS-1:0] cnt_r, cnt_nxt, init_r, init_nxt;
    logic [31:0] pbase_r, pbase_nxt, mbase_r, mbase_nxt;
    logic [31:0] pa_r, pa_nxt, ma_r, ma_nxt, data_r, data_nxt;
    logic [1:0] stat_r, stat_nxt, mask_r, mask_nxt;
    state_t st_r, st_nxt;
    logic req_s1_r, req_s2_r;
    logic ack_nxt, irq_nxt, wait_nxt;
    logic [31:0] rd_nxt;
    logic half_ev, full_ev, start;
    logic [1:0] psz, msz, src_w, dst_w;
    logic to_periph;
    logic [COUNT_BITS-1:0] half_mark;

    assign psz = cfg_r[CFG_PERIPH_ITEM_WIDTH +: 2];
    assign msz = cfg_r[CFG_MEM_ITEM_WIDTH +: 2];
    assign to_periph = cfg_r[CFG_DIR];
    assign src_w = to_periph ? msz : psz;
    assign dst_w = to_periph ? psz : msz;
    assign half_mark = init_r >> 1;

    // Only the second stage of the synchroniser is read by logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
        end else begin
            req_s1_r <= periph_req;
            req_s2_r <= req_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Transfer engine
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        pa_nxt = pa_r;
        ma_nxt = ma_r;
        data_nxt = data_r;
        ack_nxt = periph_ack;
        half_ev = 1'b0;
        full_ev = 1'b0;
        sys.req = 1'b0;
        sys.wr = 1'b0;
        sys.addr = to_periph ? ma_r : pa_r;
        sys.size = src_w;
        sys.wdata = RESET_WORD;
        // Memory copy needs no request; otherwise the peripheral must ask
        start = cfg_r[CFG_EN] && (cnt_r != '0) && // [R19] [R16] [R9]
            (cfg_r[CFG_MCOPY] || req_s2_r); // [R2] [R8]
        case (st_r)
            ST_IDLE: begin
                if (start) begin
                    st_nxt = ST_READ;
                end
            end
            ST_READ: begin
                sys.req = 1'b1; // [R3] [R11]
                if (sys.done) begin
                    data_nxt = trim(sys.rdata, src_w); // [R12]
                    st_nxt = ST_WRITE;
                end
            end
            ST_WRITE: begin
                sys.req = 1'b1;
                sys.wr = 1'b1;
                sys.addr = to_periph ? pa_r : ma_r;
                sys.size = dst_w;
                sys.wdata = trim(data_r, dst_w); // [R13] [R11]
                if (sys.done) begin
                    // Each side steps by its own width [R14] [R18]
                    if (cfg_r[CFG_PERIPH_ADDR_STEP_EN]) begin
                        pa_nxt = pa_r + step_of(psz);
                    end
                    if (cfg_r[CFG_MEM_ADDR_STEP_EN]) begin
                        ma_nxt = ma_r + step_of(msz);
                    end
                    cnt_nxt = cnt_r - 1'b1; // [R4]
                    half_ev = (cnt_nxt == half_mark); // [R5]
                    if (cnt_nxt == '0) begin
                        full_ev = 1'b1; // [R6]
                        if (cfg_r[CFG_WRAP]) begin
                            cnt_nxt = init_r; // [R7]
                            pa_nxt = pbase_r; // [R17]
                            ma_nxt = mbase_r; // [R17]
                        end
                    end
                    ack_nxt = !cfg_r[CFG_MCOPY];
                    st_nxt = ST_ACK;
                end
            end
            ST_ACK: begin
                // Ack drops only once the request has gone [R15]
                if (!periph_ack || !req_s2_r) begin
                    ack_nxt = 1'b0;
                    st_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                // Let the synchronised request settle before re-arming
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    dma_sys_port u_port (
        .clk(clk),
        .rst_n(rst_n),
        .sp(sys.port),
        .m_read(m_read),
        .m_write(m_write),
        .m_address(m_address),
        .m_byteenable(m_byteenable),
        .m_writedata(m_writedata),
        .m_readdata(m_readdata),
        .m_waitrequest(m_waitrequest)
    );

    // ----------------------------------------------------------------
    // Avalon slave register file
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic wr_acc, rd_acc;
    logic [31:0] cfg_w, cnt_w;
    assign wr_acc = avs_write && avs_waitrequest;
    assign rd_acc = avs_read && avs_waitrequest;

    always_comb begin
        cfg_nxt = cfg_r;
        init_nxt = init_r;
        pbase_nxt = pbase_r;
        mbase_nxt = mbase_r;
        mask_nxt = mask_r;
        rd_nxt = avs_readdata;
        cfg_w = merge({17'h0_0000, cfg_r}, avs_writedata, avs_byteenable);
        cnt_w = merge({16'h0000, init_r}, avs_writedata, avs_byteenable);
        // Hardware set wins over a write-one clear in the same cycle
        stat_nxt = stat_r;
        if (wr_acc && avs_address == OFS_STATUS && avs_byteenable[0]) begin
            stat_nxt = stat_r & ~avs_writedata[1:0];
        end
        stat_nxt[STAT_HALF] = stat_nxt[STAT_HALF] | half_ev; // [R5]
        stat_nxt[STAT_FULL] = stat_nxt[STAT_FULL] | full_ev; // [R6]
        if (wr_acc) begin
            case (avs_address)
                OFS_CONFIG: cfg_nxt = cfg_w[CFG_BITS-1:0]; // [R10] not enforced: CFG_MCOPY and CFG_WRAP are both accepted as written
                OFS_COUNT: begin
                    if (!cfg_r[CFG_EN]) begin
                        init_nxt = cnt_w[COUNT_BITS-1:0]; // [R16]
                    end
                end
                OFS_PERIPH: begin
                    if (!cfg_r[CFG_EN]) begin
                        pbase_nxt = merge(pbase_r, avs_writedata,
                            avs_byteenable);
                    end
                end
                OFS_MEM: begin
                    if (!cfg_r[CFG_EN]) begin
                        mbase_nxt = merge(mbase_r, avs_writedata,
                            avs_byteenable);
                    end
                end
                OFS_MASK: begin
                    if (avs_byteenable[0]) begin
                        mask_nxt = avs_writedata[1:0];
                    end
                end
                default: begin
                    // Read-only and unmapped words ignore writes
                end
            endcase
        end
        if (rd_acc) begin
            case (avs_address)
                OFS_CONFIG: rd_nxt = {17'h0_0000, cfg_r};
                OFS_COUNT: rd_nxt = {16'h0000, cnt_r};
                OFS_PERIPH: rd_nxt = pbase_r;
                OFS_MEM: rd_nxt = mbase_r;
                OFS_STATUS: rd_nxt = {30'h0000_0000, stat_r};
                OFS_MASK: rd_nxt = {30'h0000_0000, mask_r};
                OFS_CUR_PA: rd_nxt = pa_r;
                OFS_CUR_MA: rd_nxt = ma_r;
                default: rd_nxt = UNMAPPED_READ;
            endcase
        end
        // One wait state per access, then release
        wait_nxt = !(avs_read || avs_write) || !avs_waitrequest;
        irq_nxt = |(stat_nxt & mask_r &
            {cfg_r[CFG_FULL_IE], cfg_r[CFG_HALF_IE]}); // [R5] [R6]
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            cfg_r <= '0;
            init_r <= '0;
            cnt_r <= '0;
            pbase_r <= RESET_WORD;
            mbase_r <= RESET_WORD;
            pa_r <= RESET_WORD;
            ma_r <= RESET_WORD;
            data_r <= RESET_WORD;
            stat_r <= 2'b00;
            mask_r <= 2'b11;
            periph_ack <= 1'b0;
            irq <= 1'b0;
            avs_readdata <= RESET_WORD;
            avs_waitrequest <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cfg_r <= cfg_nxt;
            init_r <= init_nxt;
            pbase_r <= pbase_nxt;
            mbase_r <= mbase_nxt;
            // A fresh enable reloads count and pointers from set-up
            if (cfg_nxt[CFG_EN] && !cfg_r[CFG_EN]) begin
                cnt_r <= init_nxt;
                pa_r <= pbase_nxt;
                ma_r <= mbase_nxt;
            end else begin
                cnt_r <= cnt_nxt;
                pa_r <= pa_nxt;
                ma_r <= ma_nxt;
            end
            data_r <= data_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            periph_ack <= ack_nxt; // [R15]
            irq <= irq_nxt;
            avs_readdata <= rd_nxt;
            avs_waitrequest <= wait_nxt;
        end
    end
endmodule : dma_channel_transfer_engine

// ==== dv/dma_chan_checker.sv ====
`timescale 1ns/10ps
module dma_chan_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic periph_req,
    input wire logic periph_ack,
    input wire logic m_read,
    input wire logic m_write,
    input wire logic [31:0] m_address,
    input wire logic [3:0] m_byteenable,
    input wire logic [31:0] m_writedata,
    input wire logic m_waitrequest
);
    // ----------------------------------------------------------------
    // Read seen before the write of an item
    // ----------------------------------------------------------------
    logic rd_done_r;
    logic rd_done_nxt;
    always_comb begin
        rd_done_nxt = rd_done_r;
        if (m_read && !m_waitrequest) begin
            rd_done_nxt = 1'b1;
        end
        if (m_write && !m_waitrequest) begin
            rd_done_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        rd_done_r <= rst_n ? rd_done_nxt : 1'b0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_ack_needs_req:
        assert property ($rose(periph_ack) |-> periph_req)
        else $error("ack rose with no request");
    a_ack_holds_req:
        assert property (periph_ack && periph_req |=> periph_ack)
        else $error("ack dropped while request high");
    a_ack_drops_late:
        assert property ($fell(periph_req) |-> ##[1:4] !periph_ack)
        else $error("ack stuck after request fell");
    a_rw_never_both:
        assert property (!(m_read && m_write))
        else $error("read and write together");
    a_read_held:
        assert property (m_read && m_waitrequest |=>
            m_read && $stable(m_address))
        else $error("read released before answer");
    a_write_held:
        assert property (m_write && m_waitrequest |=> m_write &&
            $stable(m_address) && $stable(m_writedata))
        else $error("write released before answer");
    a_write_after_read:
        assert property (m_write |-> rd_done_r)
        else $error("write with no read before it");
    a_lane_legal:
        assert property (m_write |-> m_byteenable inside
            {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
        else $error("byte lanes do not match an item size");
    a_word_aligned:
        assert property (m_read || m_write |-> m_address[1:0] == 2'h0)
        else $error("bus address not word aligned");
endmodule : dma_chan_checker

bind dma_channel_transfer_engine dma_chan_checker chk (.clk, .rst_n,
    .periph_req, .periph_ack, .m_read, .m_write, .m_address,
    .m_byteenable, .m_writedata, .m_waitrequest);

// ==== dv/mem_model.sv ====
`timescale 1ns/10ps
module mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic m_read,
    input wire logic m_write,
    input wire logic [31:0] m_address,
    input wire logic [3:0] m_byteenable,
    input wire logic [31:0] m_writedata,
    output logic [31:0] m_readdata,
    output logic m_waitrequest
);
    logic [31:0] mem [128];
    logic [6:0] ix;
    int dly;
    assign ix = m_address[8:2];
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i / 4][8 * (i % 4) +: 8] = 8'(i) ^ 8'hA5;
        end
    end
    // Random stalls; an idle data bus shows the inverse of its last word
    always @(posedge clk) begin
        if (!rst_n) begin
            m_waitrequest <= 1'b1;
            m_readdata <= 32'h0;
            dly <= 0;
        end else if (!m_waitrequest) begin
            for (int b = 0; b < 4; b++) begin
                if (m_write && m_byteenable[b]) begin
                    mem[ix][8 * b +: 8] <= m_writedata[8 * b +: 8];
                end
            end
            m_waitrequest <= 1'b1;
            m_readdata <= ~m_readdata;
            dly <= $urandom_range(3);
        end else if ((m_read || m_write) && dly == 0) begin
            m_waitrequest <= 1'b0;
            m_readdata <= mem[ix];
        end else if (m_read || m_write) begin
            dly <= dly - 1;
        end
    end
endmodule : mem_model

// ==== dv/dma_channel_transfer_engine_tb_top.sv ====
`timescale 1ns/10ps
module dma_channel_transfer_engine_tb_top;
    import dma_chan_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic periph_req = 1'b0;
    logic periph_ack;
    logic m_read;
    logic m_write;
    logic [31:0] m_address;
    logic [3:0] m_byteenable;
    logic [31:0] m_writedata;
    logic [31:0] m_readdata;
    logic m_waitrequest;
    logic rd_chk = 1'b0;
    logic [31:0] rq [$];
    logic [67:0] wq [$];
    logic [67:0] e;
    int err_count = 0;
    int compares = 0;
    always #5 clk = ~clk;
    dma_channel_transfer_engine dut (.clk, .rst_n, .avs_address,
        .avs_read, .avs_write, .avs_byteenable(4'hF), .avs_writedata,
        .avs_readdata, .avs_waitrequest, .irq, .periph_req, .periph_ack,
        .m_read, .m_write, .m_address, .m_byteenable, .m_writedata,
        .m_readdata, .m_waitrequest);
    mem_model far (.clk, .rst_n, .m_read, .m_write, .m_address,
        .m_byteenable, .m_writedata, .m_readdata, .m_waitrequest);
    function automatic logic [31:0] src(input int a, input int n);
        logic [31:0] v;
        v = 32'h0;
        for (int k = 0; k < n; k++) begin
            v[8 * k +: 8] = 8'(a + k) ^ 8'hA5;
        end
        return v;
    endfunction : src
    task automatic cmp(input logic [67:0] got, input logic [67:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic exp_w(input logic [31:0] a, input int n,
        input logic [31:0] v);
        wq.push_back({a & 32'hFFFF_FFFC, 4'((1 << n) - 1) << a[1:0],
            v << (8 * a[1:0])});
    endtask : exp_w
    // Results are judged here, in the order they were noted
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && rd_chk) begin
            cmp(avs_readdata, rq.pop_front());
        end
        if (m_write && m_waitrequest === 1'b0) begin
            cmp(1'b1, wq.size() != 0);
            if (wq.size() != 0) begin
                e = wq.pop_front();
                cmp({m_address, m_byteenable, m_writedata & {{8{e[35]}},
                    {8{e[34]}}, {8{e[33]}}, {8{e[32]}}}}, e);
            end
        end
    end
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, input logic c, output logic [31:0] q);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        rd_chk <= c;
        // Only the watchdog ends a wait that is never answered
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 1'b0, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        logic [31:0] q;
        rq.push_back(x);
        bus(1'b0, a, 32'h0, 1'b1, q);
    endtask : rd
    task automatic wait_full;
        logic [31:0] q;
        q = 32'h0;
        for (int n = 0; n < 100 && q[STAT_FULL] !== 1'b1; n++) begin
            bus(1'b0, OFS_STATUS, 32'h0, 1'b0, q);
        end
    endtask : wait_full
    task automatic serve(input logic want);
        int n;
        @(posedge clk);
        periph_req <= 1'b1;
        for (n = 0; n < 60 && periph_ack !== 1'b1; n++) @(posedge clk);
        cmp(periph_ack, want);
        periph_req <= 1'b0;
        for (n = 0; n < 60 && periph_ack !== 1'b0; n++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : serve
    task automatic test_done;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    // Whole run is about a thousand cycles; this bound is 30000 cycles, over twenty times that
    initial begin
        #300000;
        err_count++;
        test_done();
    end
    initial begin
        logic [31:0] q;
        int nbs;
        int nbd;
        void'($urandom(32'h9EEB));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), i == 5 ? 32'h3 : (i > 7 ? UNMAPPED_READ : RESET_WORD));
        end
        $display("test reset done");
        for (int p = 0; p < 3; p++) begin
            for (int m = 0; m < 3; m++) begin
                nbs = 1 << p;
                nbd = 1 << m;
                for (int k = 0; k < 4; k++) begin
                    exp_w(32'h100 + k * nbd, nbd,
                        src(k * nbs, nbs < nbd ? nbs : nbd));
                end
                wr(OFS_PERIPH, 32'h0);
                wr(OFS_MEM, 32'h100);
                wr(OFS_COUNT, 32'h4);
                q = 32'h40C6 | (p << 8) | (m << 10) |
                    ($urandom_range(3) << 12);
                wr(OFS_CONFIG, q);
                wr(OFS_CONFIG, q | 32'h1);
                wait_full();
                rd(OFS_STATUS, 32'h3);
                rd(OFS_COUNT, 32'h0);
                #1 cmp(irq, 1'b1);
                if (p == 2 && m == 2) begin
                    wr(OFS_MASK, 32'h0);
                    rd(OFS_MASK, 32'h0);
                    #1 cmp(irq, 1'b0);
                    wr(OFS_MASK, 32'h3);
                end
                wr(OFS_STATUS, 32'h3);
                rd(OFS_STATUS, 32'h0);
                #1 cmp(irq, 1'b0);
                wr(OFS_CONFIG, 32'h0);
            end
        end
        $display("test copy done");
        wr(OFS_PERIPH, 32'h180);
        wr(OFS_MEM, 32'h10);
        wr(OFS_COUNT, 32'h2);
        wr(OFS_CONFIG, 32'hAB2);
        wr(OFS_CONFIG, 32'hAB3);
        for (int k = 0; k < 4; k++) begin
            exp_w(32'h180, 4, src(16 + 4 * (k % 2), 4));
            serve(1'b1);
            rd(OFS_COUNT, (k % 2) ? 32'h2 : 32'h1);
        end
        rd(OFS_CUR_MA, 32'h10);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_STATUS, 32'h3);
        wr(OFS_CONFIG, 32'h0);
        $display("test wrap done");
        exp_w(32'h1C1, 1, src(35, 1));
        wr(OFS_PERIPH, 32'h23);
        wr(OFS_MEM, 32'h1C1);
        wr(OFS_COUNT, 32'h1);
        wr(OFS_CONFIG, 32'h1);
        serve(1'b1);
        wr(OFS_COUNT, 32'h5);
        rd(OFS_COUNT, 32'h0);
        serve(1'b0);
        wr(OFS_CONFIG, 32'h0);
        wr(OFS_COUNT, 32'h3);
        serve(1'b0);
        exp_w(32'h1C1, 1, src(35, 1));
        wr(OFS_CONFIG, 32'h1);
        serve(1'b1);
        rd(OFS_COUNT, 32'h2);
        cmp(wq.size() == 0, 1'b1);
        $display("test refuse done");
        test_done();
    end
endmodule : dma_channel_transfer_engine_tb_top
